// ---- verif/repeater_smbus_status_routing_asserts.sv ----
// port assertions for the repeater configuration block
`timescale 1ns/1ns
`default_nettype none
module repeater_status_checker
	import repeater_cfg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_smb_clk,
	input wire logic o_sda_oe,
	input wire logic i_mgmt_mode_strap,
	input wire logic [3:0] o_gpio_out,
	input wire logic [3:0] o_gpio_oe,
	input wire logic [7:0] i_idle_det,
	input wire logic [7:0] i_rate_det,
	input wire logic i_power_down_pin,
	input wire logic [1:0] i_idle_control_straps,
	input wire logic [1:0] i_rate_select_strap,
	input wire logic [7:0] o_per_channel_power_down,
	input wire logic o_ch0_idle_auto,
	input wire logic o_ch0_rate_auto
);
	logic [3:0] pin_src;
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			pin_src[k] = i_idle_det[k + 2 * (k / 2)] | i_idle_det[k + 2 * (k / 2) + 2]
				| i_rate_det[k + 2 * (k / 2)] | i_rate_det[k + 2 * (k / 2) + 2];
	end
	// ************
	// sequences and properties
	// ************
	sequence s_mode_off;
		!i_mgmt_mode_strap [*4];
	endsequence
	sequence s_off_pin_hi;
		(!i_mgmt_mode_strap && i_power_down_pin) [*4];
	endsequence
	sequence s_off_pin_lo;
		(!i_mgmt_mode_strap && !i_power_down_pin) [*4];
	endsequence
	property p_oe_needs_mode;
		@(posedge i_clk) disable iff (i_rst) s_mode_off |=> o_gpio_oe == 4'h0;
	endproperty
	property p_oe_uniform;
		@(posedge i_clk) disable iff (i_rst)
			o_gpio_oe == 4'h0 || (o_gpio_oe == 4'hf && $past(i_mgmt_mode_strap, 3));
	endproperty
	// a rise needs a source seen high within the sync delay
	property p_pin_cause;
		@(posedge i_clk) disable iff (i_rst)
			(o_gpio_out & ~$past(o_gpio_out) & ~$past(pin_src, 2) & ~$past(pin_src, 3) & ~$past(pin_src, 4)) == 4'h0;
	endproperty
	property p_pd_pin_hi;
		@(posedge i_clk) disable iff (i_rst) s_off_pin_hi |=> o_per_channel_power_down == 8'hff;
	endproperty
	property p_pd_pin_lo;
		@(posedge i_clk) disable iff (i_rst) s_off_pin_lo |=> o_per_channel_power_down == 8'h00;
	endproperty
	property p_quiet_off_mode;
		@(posedge i_smb_clk) disable iff (i_rst) !i_mgmt_mode_strap [*8] |=> !o_sda_oe;
	endproperty
	property p_idle_auto_float;
		@(posedge i_clk) disable iff (i_rst)
			(!i_mgmt_mode_strap && i_idle_control_straps == STRAP_FLOAT) [*4] |=> o_ch0_idle_auto;
	endproperty
	property p_rate_auto_float;
		@(posedge i_clk) disable iff (i_rst)
			(!i_mgmt_mode_strap && i_rate_select_strap == STRAP_FLOAT) [*4] |=> o_ch0_rate_auto;
	endproperty
	a_oe_needs_mode: assert property (p_oe_needs_mode)
		else $error("status pins driven outside management mode");
	a_oe_uniform: assert property (p_oe_uniform)
		else $error("status pin enables differ");
	a_pin_cause: assert property (p_pin_cause)
		else $error("status pin rose with no source high");
	a_pd_pin_hi: assert property (p_pd_pin_hi)
		else $error("power down pin high not followed");
	a_pd_pin_lo: assert property (p_pd_pin_lo)
		else $error("power down pin low not followed");
	a_quiet_off_mode: assert property (p_quiet_off_mode)
		else $error("data line pulled outside management mode");
	a_idle_auto_float: assert property (p_idle_auto_float)
		else $error("floating idle strap gave no automatic idle");
	a_rate_auto_float: assert property (p_rate_auto_float)
		else $error("floating rate strap gave no automatic rate");
endmodule : repeater_status_checker
bind repeater_smbus_status_routing repeater_status_checker u_checker (.i_clk(i_clk), .i_rst(i_rst),
	.i_smb_clk(i_smb_clk), .o_sda_oe(o_sda_oe), .i_mgmt_mode_strap(i_mgmt_mode_strap), .o_gpio_out(o_gpio_out),
	.o_gpio_oe(o_gpio_oe), .i_idle_det(i_idle_det), .i_rate_det(i_rate_det), .i_power_down_pin(i_power_down_pin),
	.i_idle_control_straps(i_idle_control_straps), .i_rate_select_strap(i_rate_select_strap),
	.o_per_channel_power_down(o_per_channel_power_down), .o_ch0_idle_auto(o_ch0_idle_auto),
	.o_ch0_rate_auto(o_ch0_rate_auto));
`default_nettype wire

// ---- verif/smbus_host_model.sv ----
// serial management host model driving the clock and open-drain data wire
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model #(parameter int QP = 200)
(
	input wire logic i_sda_oe,
	input wire logic i_sda_out,
	output logic o_scl,
	output logic o_sda
);
	logic drive_low;
	// ************
	// wire and bit level
	// ************
	// pull-up wins when nobody pulls low
	assign o_sda = ~(drive_low | (i_sda_oe & ~i_sda_out));
	initial
	begin
		o_scl = 1'b1;
		drive_low = 1'b0;
	end
	task automatic put_bit(input logic b);
		drive_low = ~b;
		#QP o_scl = 1'b1;
		#(2 * QP) o_scl = 1'b0;
		#QP;
	endtask : put_bit
	task automatic get_bit(output logic b);
		drive_low = 1'b0;
		#QP o_scl = 1'b1;
		#QP b = o_sda;
		#QP o_scl = 1'b0;
		#QP;
	endtask : get_bit
	// also serves as repeated start
	task automatic start_cond();
		drive_low = 1'b0;
		#QP o_scl = 1'b1;
		#QP drive_low = 1'b1;
		#QP o_scl = 1'b0;
		#QP;
	endtask : start_cond
	task automatic stop_cond();
		drive_low = 1'b1;
		#QP o_scl = 1'b1;
		#QP drive_low = 1'b0;
		#(2 * QP);
	endtask : stop_cond
	task automatic put_byte(input logic [7:0] d, inout logic ok);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(a);
		ok = ok & ~a;
	endtask : put_byte
	// ************
	// register transfers
	// ************
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, output logic ok);
		ok = 1'b1;
		start_cond();
		put_byte({dev, 1'b0}, ok);
		put_byte(ofs, ok);
		put_byte(d, ok);
		stop_cond();
	endtask : write_reg
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d, output logic ok);
		logic b;
		ok = 1'b1;
		start_cond();
		put_byte({dev, 1'b0}, ok);
		put_byte(ofs, ok);
		start_cond();
		put_byte({dev, 1'b1}, ok);
		for (int i = 7; i >= 0; i--)
		begin
			get_bit(b);
			d[i] = b;
		end
		// nack ends the read, no auto increment wanted
		put_bit(1'b1);
		stop_cond();
	endtask : read_reg
endmodule : smbus_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the repeater configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import repeater_cfg_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_smb_clk = 1'b1;
	logic i_rst = 1'b1;
	logic mode = 1'b1;
	logic pd_pin = 1'b0;
	logic [3:0] ad_drv = 4'h0;
	logic [7:0] idle_det = 8'h00;
	logic [7:0] rate_det = 8'h00;
	logic [3:0] gpio_in, gpio_out, gpio_oe;
	logic [7:0] pd_out, rd, r47, r4c;
	logic scl, sda, sda_out, sda_oe, idle_auto, idle_mute, rate_auto, rate_high, ok;
	logic [6:0] dev;
	logic [7:0] ofs_all [8] = '{OFS_SOFT_RESET, OFS_CHANNEL_POWER_DOWN, OFS_POWER_DOWN_PIN_OVERRIDE,
		OFS_STRAP_PIN_OVERRIDE, OFS_CH0_IDLE_RATE_SELECT, OFS_IDLE_STATUS_ROUTE, OFS_RATE_STATUS_ROUTE,
		OFS_STATUS_PIN_OUTPUT_ENABLE};
	int miscompares = 0;
	int comparisons = 0;
	// ************
	// clocks, shared pins, instances
	// ************
	always #20 i_clk = ~i_clk;
	always #16 i_smb_clk = ~i_smb_clk;
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ad_drv);
	repeater_smbus_status_routing u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_smb_clk(i_smb_clk), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_mgmt_mode_strap(mode), .i_gpio_in(gpio_in),
		.o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe), .i_idle_det(idle_det), .i_rate_det(rate_det),
		.i_power_down_pin(pd_pin), .i_idle_control_straps(STRAP_FLOAT), .i_rate_select_strap(STRAP_FLOAT),
		.o_per_channel_power_down(pd_out), .o_ch0_idle_auto(idle_auto), .o_ch0_idle_mute(idle_mute),
		.o_ch0_rate_auto(rate_auto), .o_ch0_rate_high(rate_high));
	smbus_host_model u_host (.i_sda_oe(sda_oe), .i_sda_out(sda_out), .o_scl(scl), .o_sda(sda));
	// ************
	// helpers
	// ************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// wait margin covers both sync chains
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		u_host.write_reg(dev, ofs, d, ok);
		check({7'h0, ok}, 8'h01);
		repeat (8) @(posedge i_clk);
	endtask : wr
	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
		u_host.read_reg(dev, ofs, rd, ok);
		check({7'h0, ok}, 8'h01);
		check(rd, exp);
	endtask : rd_chk
	task automatic drive(input logic [7:0] idl, input logic [7:0] rt);
		@(posedge i_clk);
		idle_det <= idl;
		rate_det <= rt;
		repeat (6) @(posedge i_clk);
	endtask : drive
	function automatic logic [3:0] exp_pins(input logic [7:0] ri, input logic [7:0] rr);
		logic [3:0] p;
		int lo;
		for (int k = 0; k < 4; k++)
		begin
			lo = k + 2 * (k / 2);
			p[k] = (ri[4] & idle_det[lo]) | (ri[5] & idle_det[lo + 2]) | (rr[6] & rate_det[lo]) | (rr[7] & rate_det[lo + 2]);
		end
		return p;
	endfunction : exp_pins
	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (90000) @(posedge i_clk);
		miscompares++;
		finish_test();
	end
	// ************
	// tests
	// ************
	initial
	begin
		void'($urandom(32'h69ed));
		ad_drv = 4'($urandom);
		dev = {SMB_ADDR_PREFIX, ad_drv};
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (8) @(posedge i_clk);
		foreach (ofs_all[i])
			rd_chk(ofs_all[i], 8'h00);
		wr(8'h05, 8'hff);
		rd_chk(8'h05, 8'h00);
		check({7'h0, sda_out}, 8'h00);
		$display("test defaults done");
		wr(OFS_STATUS_PIN_OUTPUT_ENABLE, 8'h01);
		check({4'h0, gpio_oe}, 8'h0f);
		@(posedge i_clk);
		ad_drv <= ~ad_drv;
		for (int n = 0; n < 12; n++)
		begin
			r47 = (n == 0) ? 8'h32 : (n == 1) ? 8'h00 : {2'h0, 2'($urandom), 4'h0};
			r4c = (n == 1) ? 8'hc0 : (n == 0) ? 8'h00 : {2'($urandom), 6'h0};
			wr(OFS_IDLE_STATUS_ROUTE, r47);
			wr(OFS_RATE_STATUS_ROUTE, r4c);
			drive(8'($urandom), 8'($urandom));
			check({4'h0, gpio_out}, {4'h0, exp_pins(r47, r4c)});
			drive(~idle_det, ~rate_det);
			check({4'h0, gpio_out}, {4'h0, exp_pins(r47, r4c)});
			if (n < 2)
				rd_chk(OFS_IDLE_STATUS_ROUTE, r47);
		end
		$display("test status routing done");
		for (int n = 0; n < 4; n++)
		begin
			r47 = (n == 0) ? 8'h00 : (n == 3) ? 8'hff : 8'($urandom);
			wr(OFS_CHANNEL_POWER_DOWN, r47);
			wr(OFS_POWER_DOWN_PIN_OVERRIDE, {7'h0, n[1]});
			@(posedge i_clk);
			pd_pin <= n[0];
			repeat (6) @(posedge i_clk);
			check(pd_out, n[1] ? r47 : (r47 | {8{n[0]}}));
		end
		$display("test power down done");
		wr(OFS_STRAP_PIN_OVERRIDE, 8'h14);
		for (int n = 0; n < 16; n++)
		begin
			wr(OFS_CH0_IDLE_RATE_SELECT, {2'h0, 2'(n >> 2), 2'h0, 2'(n)});
			check({4'h0, idle_auto, idle_mute, rate_auto, rate_high},
				{4'h0, n[3], n[2] & ~n[3], n[1], n[0] & ~n[1]});
		end
		wr(OFS_STRAP_PIN_OVERRIDE, 8'h00);
		check({6'h0, idle_auto, rate_auto}, 8'h03);
		$display("test channel control done");
		@(posedge i_clk);
		mode <= 1'b0;
		repeat (8) @(posedge i_clk);
		check({4'h0, gpio_oe}, 8'h00);
		check(pd_out, 8'hff);
		pd_pin <= 1'b0;
		u_host.write_reg(dev, OFS_SOFT_RESET, 8'h01, ok);
		check({7'h0, ok}, 8'h00);
		check(pd_out, 8'h00);
		@(posedge i_clk);
		mode <= 1'b1;
		repeat (8) @(posedge i_clk);
		check({4'h0, gpio_oe}, 8'h0f);
		rd_chk(OFS_CH0_IDLE_RATE_SELECT, 8'h33);
		u_host.write_reg(dev ^ 7'h01, OFS_SOFT_RESET, 8'h01, ok);
		check({7'h0, ok}, 8'h00);
		$display("test refusals done");
		wr(OFS_SOFT_RESET, 8'h01);
		// frozen address is released with the output enable
		dev = {SMB_ADDR_PREFIX, ad_drv};
		check({4'h0, gpio_oe}, 8'h00);
		rd_chk(OFS_CH0_IDLE_RATE_SELECT, 8'h00);
		rd_chk(OFS_SOFT_RESET, 8'h00);
		$display("test soft reset done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire

// ---- verilog/repeater_cfg_pkg.sv ----
// constants and types shared by the repeater configuration block
package repeater_cfg_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_SOFT_RESET = 8'h00;
	localparam logic [7:0] OFS_CHANNEL_POWER_DOWN = 8'h01;
	localparam logic [7:0] OFS_POWER_DOWN_PIN_OVERRIDE = 8'h02;
	localparam logic [7:0] OFS_STRAP_PIN_OVERRIDE = 8'h08;
	localparam logic [7:0] OFS_CH0_IDLE_RATE_SELECT = 8'h0e;
	localparam logic [7:0] OFS_IDLE_STATUS_ROUTE = 8'h47;
	localparam logic [7:0] OFS_RATE_STATUS_ROUTE = 8'h4c;
	localparam logic [7:0] OFS_STATUS_PIN_OUTPUT_ENABLE = 8'h4e;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_SOFT_RESET = 8'h00;
	localparam logic [7:0] RST_CHANNEL_POWER_DOWN = 8'h00;
	localparam logic [7:0] RST_POWER_DOWN_PIN_OVERRIDE = 8'h00;
	localparam logic [7:0] RST_STRAP_PIN_OVERRIDE = 8'h00;
	localparam logic [7:0] RST_CH0_IDLE_RATE_SELECT = 8'h00;
	localparam logic [7:0] RST_IDLE_STATUS_ROUTE = 8'h00;
	localparam logic [7:0] RST_RATE_STATUS_ROUTE = 8'h00;
	localparam logic [7:0] RST_STATUS_PIN_OUTPUT_ENABLE = 8'h00;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int SOFT_RESET_BIT = 0;
	localparam int POWER_DOWN_PIN_BLOCK_BIT = 0;
	localparam int IDLE_PIN_BLOCK_BIT = 4;
	localparam int RATE_PIN_BLOCK_BIT = 2;
	localparam int IDLE_AUTO_BIT = 5;
	localparam int IDLE_MUTE_BIT = 4;
	localparam int RATE_AUTO_BIT = 1;
	localparam int RATE_HIGH_BIT = 0;
	localparam int IDLE_ROUTE_LO_BIT = 4;
	localparam int IDLE_ROUTE_HI_BIT = 5;
	localparam int RATE_ROUTE_LO_BIT = 6;
	localparam int RATE_ROUTE_HI_BIT = 7;
	localparam int STATUS_PIN_OE_BIT = 0;
	// ************************************************************
	// strap encodings and serial port constants
	// ************************************************************
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_FLOAT = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;
	localparam logic [2:0] SMB_ADDR_PREFIX = 3'h5;
	localparam logic [3:0] SMB_BYTE_BITS = 4'h8;
	localparam int STATUS_PINS = 4;
	localparam int CHANNELS = 8;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_TX, ST_MACK} smb_state_t;
endpackage : repeater_cfg_pkg

// ---- verilog/repeater_smbus_status_routing.sv ----
// configuration registers, serial management port and status pin routing
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - status pins drive outputs only while the management mode strap is high
// - output-enable bit 0 turns all four general pins into status drivers
// - idle route bits 5:4 and rate route bits 7:6 gate status onto pins
// - status blocks enabled onto one pin are combined by logical OR
// - idle route value 32 gives pairs 0|2, 1|3, 4|6, 5|7 on pins
// - idle status pin is high for electrical idle, low for active data
// - rate route value c0 gives the same pairing for rate status
// - rate status pin is high for higher rate, low for lower rate
// - writing 1 to soft reset bit 0 returns all registers to defaults
// - channel power-down register holds one bit per channel, a side high nibble
// - power-down override bit 0 makes the device ignore the power-down pin in management mode
// - strap override bit 4 blocks idle-control strap pins in management mode
// - strap override bit 2 blocks the rate-select strap pin in management mode
// - select bit 5 picks auto idle, else bit 4 mutes output
// - select bit 1 picks auto rate, else bit 0 picks higher range
module repeater_smbus_status_routing
	import repeater_cfg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_smb_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_mgmt_mode_strap,
	input wire logic [3:0] i_gpio_in,
	output logic [3:0] o_gpio_out,
	output logic [3:0] o_gpio_oe,
	input wire logic [7:0] i_idle_det,
	input wire logic [7:0] i_rate_det,
	input wire logic i_power_down_pin,
	input wire logic [1:0] i_idle_control_straps,
	input wire logic [1:0] i_rate_select_strap,
	output logic [7:0] o_per_channel_power_down,
	output logic o_ch0_idle_auto,
	output logic o_ch0_idle_mute,
	output logic o_ch0_rate_auto,
	output logic o_ch0_rate_high
);
	// ************************************************************
	// state of the core domain
	// ************************************************************
	typedef struct packed {
		logic mgmt_s1;
		logic mgmt_s2;
		logic [7:0] idle_s1;
		logic [7:0] idle_s2;
		logic [7:0] rate_s1;
		logic [7:0] rate_s2;
		logic pd_s1;
		logic pd_s2;
		logic [1:0] istrap_s1;
		logic [1:0] istrap_s2;
		logic [1:0] rstrap_s1;
		logic [1:0] rstrap_s2;
		logic wr_s1;
		logic wr_s2;
		logic wr_seen;
		logic rd_s1;
		logic rd_s2;
		logic rd_seen;
		logic rd_ack_tgl;
		logic [7:0] rd_word;
		logic [7:0] chan_pd;
		logic [7:0] pd_override;
		logic [7:0] pin_override;
		logic [7:0] ch0_select;
		logic [7:0] idle_route;
		logic [7:0] rate_route;
		logic [7:0] pin_oe;
		logic [3:0] gpio_out;
		logic [3:0] gpio_oe;
		logic [7:0] pd_out;
		logic idle_auto;
		logic idle_mute;
		logic rate_auto;
		logic rate_high;
	} core_t;

	// ************************************************************
	// state of the serial port domain
	// ************************************************************
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic mgmt_s1;
		logic mgmt_s2;
		logic oe_s1;
		logic oe_s2;
		logic [3:0] ad_s1;
		logic [3:0] ad_s2;
		logic [3:0] dev_ad;
		logic rack_s1;
		logic rack_s2;
		logic rack_seen;
		smb_state_t state;
		logic ack;
		logic rw;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic wr_tgl;
		logic rd_tgl;
		logic [7:0] rd_data;
		logic sda_oe;
	} link_t;

	core_t c_reg;
	core_t c_next;
	link_t l_reg;
	link_t l_next;
	logic [3:0] pin_raw;

	// register read decode; unmapped offsets read as zero
	function automatic logic [7:0] reg_read(input logic [7:0] a, input core_t s);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFS_SOFT_RESET: v = RST_SOFT_RESET;
			OFS_CHANNEL_POWER_DOWN: v = s.chan_pd;
			OFS_POWER_DOWN_PIN_OVERRIDE: v = s.pd_override;
			OFS_STRAP_PIN_OVERRIDE: v = s.pin_override;
			OFS_CH0_IDLE_RATE_SELECT: v = s.ch0_select;
			OFS_IDLE_STATUS_ROUTE: v = s.idle_route;
			OFS_RATE_STATUS_ROUTE: v = s.rate_route;
			OFS_STATUS_PIN_OUTPUT_ENABLE: v = s.pin_oe;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : reg_read

	// ************************************************************
	// status pin routing
	// ************************************************************
	generate
		for (genvar k = 0; k < STATUS_PINS; k++)
		begin : g_pin
			localparam int LO = (k < 2) ? k : k + 2;
			// pairs lo channel with lo+2; enabled blocks are ORed
			assign pin_raw[k] = (c_reg.idle_route[IDLE_ROUTE_LO_BIT] & c_reg.idle_s2[LO])
				| (c_reg.idle_route[IDLE_ROUTE_HI_BIT] & c_reg.idle_s2[LO + 2])
				| (c_reg.rate_route[RATE_ROUTE_LO_BIT] & c_reg.rate_s2[LO])
				| (c_reg.rate_route[RATE_ROUTE_HI_BIT] & c_reg.rate_s2[LO + 2]);
		end
	endgenerate

	// ************************************************************
	// core domain
	// ************************************************************
	always_comb
	begin
		logic mode;
		logic idle_by_reg;
		logic rate_by_reg;
		c_next = c_reg;
		mode = c_reg.mgmt_s2;
		c_next.mgmt_s1 = i_mgmt_mode_strap;
		c_next.mgmt_s2 = c_reg.mgmt_s1;
		c_next.idle_s1 = i_idle_det;
		c_next.idle_s2 = c_reg.idle_s1;
		c_next.rate_s1 = i_rate_det;
		c_next.rate_s2 = c_reg.rate_s1;
		c_next.pd_s1 = i_power_down_pin;
		c_next.pd_s2 = c_reg.pd_s1;
		c_next.istrap_s1 = i_idle_control_straps;
		c_next.istrap_s2 = c_reg.istrap_s1;
		c_next.rstrap_s1 = i_rate_select_strap;
		c_next.rstrap_s2 = c_reg.rstrap_s1;
		c_next.wr_s1 = l_reg.wr_tgl;
		c_next.wr_s2 = c_reg.wr_s1;
		c_next.wr_seen = c_reg.wr_s2;
		c_next.rd_s1 = l_reg.rd_tgl;
		c_next.rd_s2 = c_reg.rd_s1;
		c_next.rd_seen = c_reg.rd_s2;
		// write data is held stable by the port until its next toggle
		if (c_reg.wr_s2 != c_reg.wr_seen)
		begin
			case (l_reg.wr_addr)
				OFS_SOFT_RESET:
				begin
					if (l_reg.wr_data[SOFT_RESET_BIT])
					begin
						c_next.chan_pd = RST_CHANNEL_POWER_DOWN;
						c_next.pd_override = RST_POWER_DOWN_PIN_OVERRIDE;
						c_next.pin_override = RST_STRAP_PIN_OVERRIDE;
						c_next.ch0_select = RST_CH0_IDLE_RATE_SELECT;
						c_next.idle_route = RST_IDLE_STATUS_ROUTE;
						c_next.rate_route = RST_RATE_STATUS_ROUTE;
						c_next.pin_oe = RST_STATUS_PIN_OUTPUT_ENABLE;
					end
				end
				OFS_CHANNEL_POWER_DOWN: c_next.chan_pd = l_reg.wr_data;
				OFS_POWER_DOWN_PIN_OVERRIDE: c_next.pd_override = l_reg.wr_data;
				OFS_STRAP_PIN_OVERRIDE: c_next.pin_override = l_reg.wr_data;
				OFS_CH0_IDLE_RATE_SELECT: c_next.ch0_select = l_reg.wr_data;
				OFS_IDLE_STATUS_ROUTE: c_next.idle_route = l_reg.wr_data;
				OFS_RATE_STATUS_ROUTE: c_next.rate_route = l_reg.wr_data;
				OFS_STATUS_PIN_OUTPUT_ENABLE: c_next.pin_oe = l_reg.wr_data;
				default: c_next.rate_route = c_reg.rate_route;
			endcase
		end
		if (c_reg.rd_s2 != c_reg.rd_seen)
		begin
			c_next.rd_word = reg_read(l_reg.ptr, c_reg);
			c_next.rd_ack_tgl = !c_reg.rd_ack_tgl;
		end
		// pins fall back to inputs outside management mode
		c_next.gpio_oe = {STATUS_PINS{mode & c_reg.pin_oe[STATUS_PIN_OE_BIT]}};
		c_next.gpio_out = pin_raw;
		// registers steer the lanes only in management mode
		if (mode && c_reg.pd_override[POWER_DOWN_PIN_BLOCK_BIT])
			c_next.pd_out = c_reg.chan_pd;
		else if (mode)
			c_next.pd_out = c_reg.chan_pd | {CHANNELS{c_reg.pd_s2}};
		else
			c_next.pd_out = {CHANNELS{c_reg.pd_s2}};
		idle_by_reg = mode & c_reg.pin_override[IDLE_PIN_BLOCK_BIT];
		rate_by_reg = mode & c_reg.pin_override[RATE_PIN_BLOCK_BIT];
		if (idle_by_reg)
		begin
			c_next.idle_auto = c_reg.ch0_select[IDLE_AUTO_BIT];
			c_next.idle_mute = !c_reg.ch0_select[IDLE_AUTO_BIT] & c_reg.ch0_select[IDLE_MUTE_BIT];
		end
		else
		begin
			c_next.idle_auto = (c_reg.istrap_s2 == STRAP_FLOAT);
			c_next.idle_mute = (c_reg.istrap_s2 == STRAP_HIGH);
		end
		if (rate_by_reg)
		begin
			c_next.rate_auto = c_reg.ch0_select[RATE_AUTO_BIT];
			c_next.rate_high = !c_reg.ch0_select[RATE_AUTO_BIT] & c_reg.ch0_select[RATE_HIGH_BIT];
		end
		else
		begin
			c_next.rate_auto = (c_reg.rstrap_s2 == STRAP_FLOAT);
			c_next.rate_high = (c_reg.rstrap_s2 == STRAP_HIGH);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			c_reg <= '0;
		else
			c_reg <= c_next;
	end

	// ************************************************************
	// serial port domain
	// ************************************************************
	always_comb
	begin
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		l_next = l_reg;
		l_next.scl_s1 = i_scl;
		l_next.scl_s2 = l_reg.scl_s1;
		l_next.scl_p = l_reg.scl_s2;
		l_next.sda_s1 = i_sda;
		l_next.sda_s2 = l_reg.sda_s1;
		l_next.sda_p = l_reg.sda_s2;
		l_next.mgmt_s1 = i_mgmt_mode_strap;
		l_next.mgmt_s2 = l_reg.mgmt_s1;
		l_next.oe_s1 = c_reg.pin_oe[STATUS_PIN_OE_BIT];
		l_next.oe_s2 = l_reg.oe_s1;
		l_next.ad_s1 = i_gpio_in;
		l_next.ad_s2 = l_reg.ad_s1;
		l_next.rack_s1 = c_reg.rd_ack_tgl;
		l_next.rack_s2 = l_reg.rack_s1;
		l_next.rack_seen = l_reg.rack_s2;
		scl_rise = l_reg.scl_s2 & !l_reg.scl_p;
		scl_fall = !l_reg.scl_s2 & l_reg.scl_p;
		start = l_reg.scl_s2 & l_reg.scl_p & l_reg.sda_p & !l_reg.sda_s2;
		stop = l_reg.scl_s2 & l_reg.scl_p & !l_reg.sda_p & l_reg.sda_s2;
		if (l_reg.rack_s2 != l_reg.rack_seen)
			l_next.rd_data = c_reg.rd_word;
		// address straps freeze once output-enable bit 0 is set, in or out of management mode
		if (!l_reg.oe_s2)
			l_next.dev_ad = l_reg.ad_s2;
		if (!l_reg.mgmt_s2)
		begin
			// no register access outside management mode
			l_next.state = ST_IDLE;
			l_next.ack = 1'b0;
			l_next.sda_oe = 1'b0;
		end
		else if (start)
		begin
			l_next.state = ST_ADDR;
			l_next.bitcnt = 4'h0;
			l_next.ack = 1'b0;
			l_next.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			l_next.state = ST_IDLE;
			l_next.ack = 1'b0;
			l_next.sda_oe = 1'b0;
		end
		else if (scl_rise)
		begin
			if (l_reg.state == ST_MACK)
			begin
				// master nack ends the read, ack reloads the byte
				l_next.state = l_reg.sda_s2 ? ST_IDLE : ST_ADDR;
				l_next.ack = !l_reg.sda_s2;
			end
			else if (!l_reg.ack && l_reg.state != ST_IDLE)
			begin
				l_next.bitcnt = l_reg.bitcnt + 4'h1;
				if (l_reg.state != ST_TX)
					l_next.shreg = {l_reg.shreg[6:0], l_reg.sda_s2};
			end
		end
		else if (scl_fall)
		begin
			if (l_reg.ack)
			begin
				l_next.ack = 1'b0;
				l_next.bitcnt = 4'h0;
				l_next.sda_oe = 1'b0;
				case (l_reg.state)
					ST_ADDR:
					begin
						if (l_reg.rw)
						begin
							l_next.state = ST_TX;
							l_next.shreg = l_reg.rd_data;
							l_next.sda_oe = !l_reg.rd_data[7];
						end
						else
							l_next.state = ST_REG;
					end
					ST_REG: l_next.state = ST_DATA;
					default: l_next.state = l_reg.state;
				endcase
			end
			else if (l_reg.state == ST_TX)
			begin
				if (l_reg.bitcnt == SMB_BYTE_BITS)
				begin
					l_next.sda_oe = 1'b0;
					l_next.state = ST_MACK;
				end
				else
				begin
					l_next.shreg = {l_reg.shreg[6:0], 1'b0};
					l_next.sda_oe = !l_reg.shreg[6];
				end
			end
			else if (l_reg.bitcnt == SMB_BYTE_BITS)
			begin
				case (l_reg.state)
					ST_ADDR:
					begin
						// narrow address window: only the strap bits vary
						if (l_reg.shreg[7:1] == {SMB_ADDR_PREFIX, l_reg.dev_ad})
						begin
							l_next.ack = 1'b1;
							l_next.sda_oe = 1'b1;
							l_next.rw = l_reg.shreg[0];
						end
						else
							l_next.state = ST_IDLE;
					end
					ST_REG:
					begin
						l_next.ptr = l_reg.shreg;
						l_next.rd_tgl = !l_reg.rd_tgl;
						l_next.ack = 1'b1;
						l_next.sda_oe = 1'b1;
					end
					ST_DATA:
					begin
						l_next.wr_addr = l_reg.ptr;
						l_next.wr_data = l_reg.shreg;
						l_next.wr_tgl = !l_reg.wr_tgl;
						l_next.ack = 1'b1;
						l_next.sda_oe = 1'b1;
					end
					default: l_next.state = ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge i_smb_clk or posedge i_rst)
	begin
		if (i_rst)
			l_reg <= '0;
		else
			l_reg <= l_next;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_sda_out = 1'b0;
	assign o_sda_oe = l_reg.sda_oe;
	assign o_gpio_out = c_reg.gpio_out;
	assign o_gpio_oe = c_reg.gpio_oe;
	assign o_per_channel_power_down = c_reg.pd_out;
	assign o_ch0_idle_auto = c_reg.idle_auto;
	assign o_ch0_idle_mute = c_reg.idle_mute;
	assign o_ch0_rate_auto = c_reg.rate_auto;
	assign o_ch0_rate_high = c_reg.rate_high;
endmodule : repeater_smbus_status_routing
`default_nettype wire
